// file: logic/dsa_consts.svh
// constants for the display saver and annunciator block
`ifndef DSA_CONSTS_SVH
`define DSA_CONSTS_SVH

// timing
`define DSA_CLK_MHZ 100
`define DSA_TICK_US 1000
`define DSA_IDLE_MIN 30
`define DSA_TICK_CYCLES (`DSA_TICK_US * `DSA_CLK_MHZ)
`define DSA_IDLE_TICKS (`DSA_IDLE_MIN * 60 * 1000000 / `DSA_TICK_US)

// register byte offsets
`define DSA_OFF_CTRL 8'h00
`define DSA_OFF_AMP_ACT 8'h04
`define DSA_OFF_AMP_PEND 8'h08
`define DSA_OFF_FREQ_ACT 8'h0C
`define DSA_OFF_FREQ_PEND 8'h10
`define DSA_OFF_UNITS 8'h14
`define DSA_OFF_STATUS 8'h18

// control register fields
`define DSA_CTRL_OUT_ACTIVE 0
`define DSA_CTRL_STANDBY 1
`define DSA_CTRL_ADDRESSED 2
`define DSA_CTRL_PH_LOCKED 3
`define DSA_CTRL_PH_OFFSET 4
`define DSA_CTRL_SETUP_MENU 5
`define DSA_CTRL_REMOTE 6
`define DSA_CTRL_CAL_DIAG 7
`define DSA_CTRL_ERROR_MSG 8
`define DSA_CTRL_W 9

// units register fields
`define DSA_UNITS_AMP_LSB 0
`define DSA_UNITS_FREQ_LSB 4
`define DSA_UNITS_SIGN_ACT 8
`define DSA_UNITS_SIGN_PEND 9
`define DSA_UNITS_W 10

// status register fields
`define DSA_STAT_BLANKED 0
`define DSA_STAT_UNSETTLED 1
`define DSA_STAT_SUPPRESSED 2
`define DSA_STAT_IDLE_LSB 8

// reset values
`define DSA_RST_CTRL 9'h002
`define DSA_RST_UNITS 10'h000
`define DSA_RST_DIGITS 32'h0000_0000

`endif

// file: logic/dsa_pkg.sv
// types shared by the display saver and annunciator block
package dsa_pkg;

  typedef enum logic [1:0] {
    DSA_SHOWN = 2'b01,
    DSA_BLANKED = 2'b10
  } dsa_saver_type;

endpackage

// file: logic/dsa_pin_sync.sv
// two-flop synchronisers with rising-edge detect for panel pins
`timescale 1ns/100ps
`default_nettype none

module dsa_pin_sync #(
  parameter int W = 4
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] rise
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] prev;
  } dsa_sync_state_type;

  dsa_sync_state_type s_q;
  dsa_sync_state_type s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.meta = pin_in;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // edge taken only from the second stage onward
  generate
    for (genvar i = 0; i < W; i++)
    begin : g_edge
      assign rise[i] = s_q.sync[i] & ~s_q.prev[i];
    end
  endgenerate

endmodule

`default_nettype wire

// file: logic/dsa_display_saver.sv
// display saver and output display annunciator logic with apb registers
//
// Contract
// - blank display after 30 idle minutes
// - clear-entry key restores blanked display only
// - other key or knob restores and acts
// - setup menu shown prevents blanking
// - remote control prevents blanking
// - calibration or diagnostics prevents blanking
// - shown error message prevents blanking
// - operate lit while output active
// - standby lit while in standby
// - addressed lit while bus addressed
// - phase lock lit while locked to reference
// - phase offset lit while offset programmed
// - unsettled lit from change until settled
// - amplitude eight digits, sign, pending in standby
// - frequency five digits, pending in standby
// - four unit indicators per display line
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "dsa_consts.svh"

module dsa_display_saver #(
  parameter int TICK_CYCLES = `DSA_TICK_CYCLES,
  parameter int IDLE_TICKS = `DSA_IDLE_TICKS,
  parameter int AMP_DIGITS = 8,
  parameter int FREQ_DIGITS = 5,
  parameter int UNIT_LAMPS = 4
) (
  input wire logic mclk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // front panel pins
  input wire logic clear_entry_key,
  input wire logic command_key,
  input wire logic knob_step,
  input wire logic output_settled,
  // events passed on to the command logic
  output logic clear_entry_evt,
  output logic command_key_evt,
  output logic knob_evt,
  // control display
  output logic control_display_blank,
  // output display annunciators
  output logic operate_indicator,
  output logic standby_indicator,
  output logic addressed_indicator,
  output logic phase_locked_indicator,
  output logic phase_offset_indicator,
  output logic unsettled_indicator,
  // output display lines
  output logic [4*AMP_DIGITS-1:0] amp_digits,
  output logic amp_sign,
  output logic [UNIT_LAMPS-1:0] amp_units,
  output logic [4*FREQ_DIGITS-1:0] freq_digits,
  output logic [UNIT_LAMPS-1:0] freq_units
);
  import dsa_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    dsa_saver_type saver;
    logic [31:0] tick_cnt;
    logic tick;
    logic [31:0] idle_cnt;
    logic [`DSA_CTRL_W-1:0] ctrl;
    logic [4*AMP_DIGITS-1:0] amp_act;
    logic [4*AMP_DIGITS-1:0] amp_pend;
    logic [4*FREQ_DIGITS-1:0] freq_act;
    logic [4*FREQ_DIGITS-1:0] freq_pend;
    logic [`DSA_UNITS_W-1:0] units;
    logic unsettled;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ce_evt;
    logic cmd_evt;
    logic knob_evt;
    logic blank;
    logic ind_operate;
    logic ind_standby;
    logic ind_addr;
    logic ind_lock;
    logic ind_offset;
    logic [4*AMP_DIGITS-1:0] amp_disp;
    logic amp_sign;
    logic [UNIT_LAMPS-1:0] amp_unit;
    logic [4*FREQ_DIGITS-1:0] freq_disp;
    logic [UNIT_LAMPS-1:0] freq_unit;
  } dsa_state_type;

  dsa_state_type s_q;
  dsa_state_type s_d;

  logic [3:0] pin_rise;
  logic ce_rise;
  logic cmd_rise;
  logic knob_rise;
  logic settle_rise;
  logic activity;
  logic suppress;
  logic apb_setup;
  logic apb_write;
  logic out_change;

  ////////////////////////////////////////////////////////////////////////////
  // panel pin synchronisers

  dsa_pin_sync #(
    .W(4)
  ) u_sync (
    .mclk(mclk),
    .reset(reset),
    .pin_in({output_settled, knob_step, command_key, clear_entry_key}),
    .rise(pin_rise)
  );

  assign ce_rise = pin_rise[0];
  assign cmd_rise = pin_rise[1];
  assign knob_rise = pin_rise[2];
  assign settle_rise = pin_rise[3];

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    s_d = s_q;
    s_d.ce_evt = 1'b0;
    s_d.cmd_evt = 1'b0;
    s_d.knob_evt = 1'b0;
    out_change = 1'b0;

    activity = ce_rise | cmd_rise | knob_rise;
    suppress = s_q.ctrl[`DSA_CTRL_SETUP_MENU]
      | s_q.ctrl[`DSA_CTRL_REMOTE]
      | s_q.ctrl[`DSA_CTRL_CAL_DIAG]
      | s_q.ctrl[`DSA_CTRL_ERROR_MSG];

    // apb: one wait cycle, answer registered in the first access cycle
    apb_setup = psel & penable & ~s_q.pready;
    apb_write = psel & penable & s_q.pready & pwrite & ~s_q.pslverr;
    s_d.pready = apb_setup;
    if (apb_setup)
    begin
      s_d.pslverr = 1'b0;
      s_d.prdata = 32'h0000_0000;
      case (paddr)
        `DSA_OFF_CTRL: s_d.prdata[`DSA_CTRL_W-1:0] = s_q.ctrl;
        `DSA_OFF_AMP_ACT: s_d.prdata[4*AMP_DIGITS-1:0] = s_q.amp_act;
        `DSA_OFF_AMP_PEND: s_d.prdata[4*AMP_DIGITS-1:0] = s_q.amp_pend;
        `DSA_OFF_FREQ_ACT: s_d.prdata[4*FREQ_DIGITS-1:0] = s_q.freq_act;
        `DSA_OFF_FREQ_PEND: s_d.prdata[4*FREQ_DIGITS-1:0] = s_q.freq_pend;
        `DSA_OFF_UNITS: s_d.prdata[`DSA_UNITS_W-1:0] = s_q.units;
        `DSA_OFF_STATUS:
        begin
          s_d.prdata[`DSA_STAT_BLANKED] = s_q.blank;
          s_d.prdata[`DSA_STAT_UNSETTLED] = s_q.unsettled;
          s_d.prdata[`DSA_STAT_SUPPRESSED] = suppress;
          s_d.prdata[31:`DSA_STAT_IDLE_LSB] = s_q.idle_cnt[23:0];
        end
        default: s_d.pslverr = 1'b1;
      endcase
    end
    else
    begin
      // error flag stands only with pready
      s_d.pslverr = 1'b0;
    end

    if (apb_write)
    begin
      case (paddr)
        `DSA_OFF_CTRL:
        begin
          s_d.ctrl = pwdata[`DSA_CTRL_W-1:0];
          out_change = (pwdata[`DSA_CTRL_OUT_ACTIVE] != s_q.ctrl[`DSA_CTRL_OUT_ACTIVE])
            | (pwdata[`DSA_CTRL_STANDBY] != s_q.ctrl[`DSA_CTRL_STANDBY]);
        end
        `DSA_OFF_AMP_ACT:
        begin
          s_d.amp_act = pwdata[4*AMP_DIGITS-1:0];
          out_change = 1'b1;
        end
        `DSA_OFF_AMP_PEND: s_d.amp_pend = pwdata[4*AMP_DIGITS-1:0];
        `DSA_OFF_FREQ_ACT:
        begin
          s_d.freq_act = pwdata[4*FREQ_DIGITS-1:0];
          out_change = 1'b1;
        end
        `DSA_OFF_FREQ_PEND: s_d.freq_pend = pwdata[4*FREQ_DIGITS-1:0];
        `DSA_OFF_UNITS:
        begin
          s_d.units = pwdata[`DSA_UNITS_W-1:0];
          out_change = 1'b1;
        end
        default: ;
      endcase
    end

    // millisecond enable
    if (s_q.tick_cnt >= 32'(TICK_CYCLES - 1))
    begin
      s_d.tick_cnt = 32'h0000_0000;
      s_d.tick = 1'b1;
    end
    else
    begin
      s_d.tick_cnt = s_q.tick_cnt + 32'h0000_0001;
      s_d.tick = 1'b0;
    end

    // idle timer
    if (activity)
    begin
      s_d.idle_cnt = 32'h0000_0000;
    end
    else if (suppress)
    begin
      s_d.idle_cnt = 32'h0000_0000;
    end
    else if (s_q.tick && s_q.idle_cnt < 32'(IDLE_TICKS))
    begin
      s_d.idle_cnt = s_q.idle_cnt + 32'h0000_0001;
    end

    // saver state machine
    case (s_q.saver)
      DSA_SHOWN:
      begin
        if (!activity && !suppress && s_q.idle_cnt >= 32'(IDLE_TICKS))
        begin
          s_d.saver = DSA_BLANKED;
        end
      end
      DSA_BLANKED:
      begin
        if (activity || suppress)
        begin
          s_d.saver = DSA_SHOWN;
        end
      end
      default: s_d.saver = DSA_SHOWN;
    endcase
    s_d.blank = (s_d.saver == DSA_BLANKED);

    // clear-entry only wakes a blank display; others always pass on
    s_d.ce_evt = ce_rise & (s_q.saver == DSA_SHOWN);
    s_d.cmd_evt = cmd_rise;
    s_d.knob_evt = knob_rise;

    // unsettled: set on output change, cleared by settle edge; set wins
    if (settle_rise)
    begin
      s_d.unsettled = 1'b0;
    end
    if (out_change)
    begin
      s_d.unsettled = 1'b1;
    end

    // annunciators
    s_d.ind_operate = s_q.ctrl[`DSA_CTRL_OUT_ACTIVE];
    s_d.ind_standby = s_q.ctrl[`DSA_CTRL_STANDBY];
    s_d.ind_addr = s_q.ctrl[`DSA_CTRL_ADDRESSED];
    s_d.ind_lock = s_q.ctrl[`DSA_CTRL_PH_LOCKED];
    s_d.ind_offset = s_q.ctrl[`DSA_CTRL_PH_OFFSET];

    // output display lines show pending values in standby
    if (s_q.ctrl[`DSA_CTRL_STANDBY])
    begin
      s_d.amp_disp = s_q.amp_pend;
      s_d.amp_sign = s_q.units[`DSA_UNITS_SIGN_PEND];
      s_d.freq_disp = s_q.freq_pend;
    end
    else
    begin
      s_d.amp_disp = s_q.amp_act;
      s_d.amp_sign = s_q.units[`DSA_UNITS_SIGN_ACT];
      s_d.freq_disp = s_q.freq_act;
    end
    s_d.amp_unit = s_q.units[`DSA_UNITS_AMP_LSB +: UNIT_LAMPS];
    s_d.freq_unit = s_q.units[`DSA_UNITS_FREQ_LSB +: UNIT_LAMPS];
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s_q <= '0;
      s_q.saver <= DSA_SHOWN;
      s_q.ctrl <= `DSA_RST_CTRL;
      s_q.units <= `DSA_RST_UNITS;
      s_q.ind_standby <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign clear_entry_evt = s_q.ce_evt;
  assign command_key_evt = s_q.cmd_evt;
  assign knob_evt = s_q.knob_evt;
  assign control_display_blank = s_q.blank;
  assign operate_indicator = s_q.ind_operate;
  assign standby_indicator = s_q.ind_standby;
  assign addressed_indicator = s_q.ind_addr;
  assign phase_locked_indicator = s_q.ind_lock;
  assign phase_offset_indicator = s_q.ind_offset;
  assign unsettled_indicator = s_q.unsettled;
  assign amp_digits = s_q.amp_disp;
  assign amp_sign = s_q.amp_sign;
  assign amp_units = s_q.amp_unit;
  assign freq_digits = s_q.freq_disp;
  assign freq_units = s_q.freq_unit;

endmodule

`default_nettype wire

// file: testbench/dsa_display_saver_chk.sv
// port assertions for the display saver and annunciator block
`timescale 1ns/100ps
`default_nettype none

module dsa_display_saver_chk #(
  parameter int TICK_CYCLES = 4,
  parameter int IDLE_TICKS = 5
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic clear_entry_key,
  input wire logic command_key,
  input wire logic knob_step,
  input wire logic clear_entry_evt,
  input wire logic command_key_evt,
  input wire logic knob_evt,
  input wire logic control_display_blank,
  input wire logic operate_indicator,
  input wire logic standby_indicator,
  input wire logic addressed_indicator,
  input wire logic phase_locked_indicator,
  input wire logic phase_offset_indicator,
  input wire logic unsettled_indicator
);
  localparam int LO = (IDLE_TICKS - 1) * TICK_CYCLES;
  localparam int HI = (IDLE_TICKS + 2) * TICK_CYCLES + 8;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////////
  // cycles since the last key activity or suppression
  logic wr;
  logic sup_q;
  int quiet_q;
  assign wr = psel && penable && pready && pwrite;
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      sup_q <= 1'b0;
      quiet_q <= 0;
    end
    else
    begin
      if (wr && paddr == 8'h00)
        sup_q <= |pwdata[8:5];
      if (clear_entry_key || command_key || knob_step || sup_q)
        quiet_q <= 0;
      else if (quiet_q < 100000)
        quiet_q <= quiet_q + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_ind;
    wr && paddr == 8'h00 |-> ##2 {phase_offset_indicator, phase_locked_indicator,
      addressed_indicator, standby_indicator, operate_indicator} == $past(pwdata[4:0], 2);
  endproperty
  a_ind: assert property (p_ind) else $error("indicators wrong");
  property p_early;
    $rose(control_display_blank) |-> quiet_q >= LO;
  endproperty
  a_early: assert property (p_early) else $error("blank too soon");
  property p_late;
    quiet_q == HI |-> control_display_blank;
  endproperty
  a_late: assert property (p_late) else $error("blank missing");
  property p_sup;
    sup_q && $past(sup_q) && $past(sup_q, 2) |-> !$rose(control_display_blank);
  endproperty
  a_sup: assert property (p_sup) else $error("blank while suppressed");
  property p_restore;
    control_display_blank && ($rose(clear_entry_key) || $rose(command_key) || $rose(knob_step))
      |-> ##[2:6] !control_display_blank;
  endproperty
  a_restore: assert property (p_restore) else $error("no restore");
  property p_act;
    command_key_evt || knob_evt |-> !control_display_blank;
  endproperty
  a_act: assert property (p_act) else $error("action while blank");
  property p_ce;
    control_display_blank |-> !clear_entry_evt;
  endproperty
  a_ce: assert property (p_ce) else $error("clear entry acted");
  property p_unset;
    wr && (paddr == 8'h04 || paddr == 8'h0C || paddr == 8'h14) |-> ##[1:2] unsettled_indicator;
  endproperty
  a_unset: assert property (p_unset) else $error("unsettled not lit");
endmodule

`default_nettype wire

// file: testbench/dsa_panel_model.sv
// operator model driving panel keys, knob and settle line
`timescale 1ns/100ps
`default_nettype none

module dsa_panel_model (
  input wire logic mclk,
  output logic clear_entry_key,
  output logic command_key,
  output logic knob_step,
  output logic output_settled
);
  logic [3:0] pin_q = 4'h0;
  assign {output_settled, knob_step, command_key, clear_entry_key} = pin_q;
  // hold line k high, then low long enough for the next edge to count
  task press(input int k, input int hold);
    @(posedge mclk);
    pin_q[k] <= 1'b1;
    repeat (hold) @(posedge mclk);
    pin_q[k] <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
endmodule

`default_nettype wire

// file: testbench/dsa_display_saver_tb_top.sv
// self-checking bench for the display saver and annunciator block
`timescale 1ns/100ps
`default_nettype none

module dsa_display_saver_tb_top;
  localparam int TK = 4;
  localparam int IT = 5;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  logic se;
  wire logic [31:0] prdata, amp_digits;
  wire logic pready, pslverr, clear_entry_key, command_key, knob_step, output_settled;
  wire logic clear_entry_evt, command_key_evt, knob_evt, control_display_blank;
  wire logic operate_indicator, standby_indicator, addressed_indicator;
  wire logic phase_locked_indicator, phase_offset_indicator, unsettled_indicator, amp_sign;
  wire logic [19:0] freq_digits;
  wire logic [3:0] amp_units, freq_units;
  wire logic [4:0] ind = {phase_offset_indicator, phase_locked_indicator,
    addressed_indicator, standby_indicator, operate_indicator};
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int ce_n = 0;
  int ak_n = 0;
  int n;
  int c;
  always #5 mclk = ~mclk;
  dsa_panel_model u_pan (.*);
  dsa_display_saver #(.TICK_CYCLES(TK), .IDLE_TICKS(IT)) dut (.*);
  always @(posedge mclk)
  begin
    ce_n += int'(clear_entry_evt === 1'b1);
    ak_n += int'(command_key_evt === 1'b1) + int'(knob_evt === 1'b1);
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task results;
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input bit ok, input string m);
    tests_run++;
    if (!ok)
    begin
      bad_count++;
      $display("Error %0t: %s", $time, m);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
    begin
      @(posedge mclk);
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let the release edge pass before any next setup
    @(posedge mclk);
  endtask
  task wt(input logic v, input int lim);
    n = 0;
    while (control_display_blank !== v && n < lim)
    begin
      @(posedge mclk);
      n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_ind;
    chk(ind === 5'h02 && control_display_blank === 1'b0, "reset state");
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, 8'h00, 32'h1 << i);
      repeat (2) @(posedge mclk);
      chk(ind === 5'h01 << i, "indicator");
    end
  endtask
  task t_keys;
    for (int k = 1; k < 3; k++)
    begin
      wt(1'b1, 200);
      c = ak_n;
      u_pan.press(k, 1);
      wt(1'b0, 10);
      @(posedge mclk);
      chk(control_display_blank === 1'b0 && ak_n == c + 1, "key restore");
      wt(1'b1, 200);
      chk(n >= (IT - 1) * TK && n <= (IT + 2) * TK + 8, "idle time");
    end
    c = ce_n;
    u_pan.press(0, 2);
    wt(1'b0, 10);
    @(posedge mclk);
    chk(control_display_blank === 1'b0 && ce_n == c, "clear entry restore");
    c = ce_n;
    u_pan.press(0, 1);
    repeat (2) @(posedge mclk);
    chk(control_display_blank === 1'b0 && ce_n == c + 1, "clear entry shown");
  endtask
  task t_sup;
    for (int b = 5; b < 9; b++)
    begin
      apb(1'b1, 8'h00, 32'h1 << b);
      wt(1'b1, 60);
      chk(control_display_blank === 1'b0, "suppressed");
    end
    apb(1'b1, 8'h00, 32'h0);
    wt(1'b1, 200);
    chk(n >= (IT - 1) * TK, "idle after suppress");
  endtask
  task t_disp;
    apb(1'b1, 8'h04, 32'h12345678);
    apb(1'b1, 8'h08, 32'h87654321);
    apb(1'b1, 8'h0C, 32'h00012345);
    apb(1'b1, 8'h10, 32'h00098765);
    apb(1'b1, 8'h14, 32'h000001A5);
    repeat (2) @(posedge mclk);
    chk(amp_digits === 32'h12345678 && freq_digits === 20'h12345, "active");
    chk(amp_units === 4'h5 && freq_units === 4'hA && amp_sign === 1'b1, "units");
    chk(unsettled_indicator === 1'b1, "unsettled");
    apb(1'b1, 8'h00, 32'h2);
    repeat (2) @(posedge mclk);
    chk(amp_digits === 32'h87654321 && freq_digits === 20'h98765
      && amp_sign === 1'b0, "pending");
    u_pan.press(3, 2);
    repeat (2) @(posedge mclk);
    chk(unsettled_indicator === 1'b0, "settled");
    apb(1'b0, 8'h40, 32'h0);
    chk(se === 1'b1 && rd === 32'h0, "unmapped");
    apb(1'b0, 8'h00, 32'h0);
    chk(se === 1'b0 && rd === 32'h0000_0002, "ctrl read");
    apb(1'b0, 8'h18, 32'h0);
    chk(se === 1'b0 && rd[2:0] === 3'h1, "status read");
  endtask
  initial
  begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_ind();
    t_keys();
    t_sup();
    t_disp();
    results();
  end
endmodule

bind dsa_display_saver dsa_display_saver_chk #(.TICK_CYCLES(TICK_CYCLES),
  .IDLE_TICKS(IDLE_TICKS)) u_chk (.*);

`default_nettype wire
